// file: include/epi_pkg.sv
`default_nettype none
package epi_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h00;
    localparam logic [7:0] ADDR_IRQ_FLAG    = 8'h04;
    localparam logic [7:0] ADDR_PINCHG_MASK = 8'h08;
    localparam logic [7:0] ADDR_MCU_CTRL    = 8'h0C;
    localparam logic [7:0] ADDR_CPU_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_LINE_STATE  = 8'h14;
    // field positions
    localparam int BIT_LINE1      = 7;
    localparam int BIT_LINE0      = 6;
    localparam int BIT_PINCHG     = 5;
    localparam int BIT_GIE        = 7;
    localparam int SENSE1_LSB     = 2;
    localparam int SENSE0_LSB     = 0;
    localparam int VEC_LINE0      = 0;
    localparam int VEC_LINE1      = 1;
    localparam int VEC_PINCHG     = 2;
    localparam int NUM_VEC        = 3;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // sense selection encodings
    localparam logic [1:0] SENSE_LOW     = 2'h0;
    localparam logic [1:0] SENSE_ANY     = 2'h1;
    localparam logic [1:0] SENSE_FALLING = 2'h2;
    localparam logic [1:0] SENSE_RISING  = 2'h3;
endpackage : epi_pkg
`default_nettype wire

// file: verilog/epi_ctrl.sv
// Notes on behaviour
// - line-1 request enabled only when mask bit 7 and global enable are set
// - line-0 request enabled only when mask bit 6 and global enable are set
// - two-bit sense field per line picks level, rising, falling or any edge
// - pin activity triggers even when the line is driven as output
// - line 1, line 0 and pin-change group each have a distinct vector request
// - pin-change request enabled only when mask bit 5 and global enable set
// - any change on a masked-in pin-change input requests the group interrupt
// - each pin-change mask bit enables change detection on its own pin
// - line-1 trigger sets flag bit 7
// - line-0 trigger sets flag bit 6
// - pin-change trigger sets flag bit 5
// - set flag plus enables make the cpu vector to the handler
// - flag clears when the cpu starts that source's handler
// - writing one clears a flag, writing zero leaves it
// - flag reads zero while line uses level sensing; level drives request
// - sense code 00 low, 01 any change, 10 falling, 11 rising
// - level sensing requests for as long as the line is low
// - lines sampled before edge detection; pulses over one clock are caught
// - pin changes and low level are detected without the clock; here wake_req is a flop and needs a pclk edge
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module epi_ctrl #(
    parameter int PC_WIDTH = 8
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          ext_line0_in,
    input  wire logic                          ext_line1_in,
    input  wire logic [PC_WIDTH-1:0]           pinchg_inputs,
    input  wire logic [epi_pkg::NUM_VEC-1:0]   irq_ack,
    output logic      [epi_pkg::NUM_VEC-1:0]   irq_vec_req,
    output logic                               wake_req
);
    logic [7:0]          irq_mask_reg_q;
    logic [7:0]          irq_flag_reg_q;
    logic [PC_WIDTH-1:0] pinchg_mask_reg_q;
    logic [3:0]          mcu_control_reg_q;
    logic                cpu_gie_q;
    logic [1:0]          line_meta_q;
    logic [1:0]          line_sync_q;
    logic [1:0]          line_prev_q;
    logic [PC_WIDTH-1:0] pc_meta_q;
    logic [PC_WIDTH-1:0] pc_sync_q;
    logic [PC_WIDTH-1:0] pc_prev_q;
    logic [1:0]          line_trig;
    logic [1:0]          line_level;
    logic [1:0]          sense [2];
    logic                pc_trig;
    logic                wr_en;
    logic                rd_en;
    logic                addr_ok;
    logic [7:0]          flag_set;
    logic [7:0]          flag_clr;
    logic [7:0]          flag_d;
    logic [31:0]         rdata_d;
    logic                wr_mask;
    logic                wr_flag;
    logic                wr_pcmask;
    logic                wr_ctrl;
    logic                wr_status;
    logic [epi_pkg::NUM_VEC-1:0] src_en;
    logic [epi_pkg::NUM_VEC-1:0] src_pend;
    logic                pc_wake;
    logic [1:0]          line_wake;

    // bits of the mask and flag registers that exist
    localparam logic [7:0] SRC_BITS = 8'((1 << epi_pkg::BIT_LINE1)
        | (1 << epi_pkg::BIT_LINE0) | (1 << epi_pkg::BIT_PINCHG));

    // writes land at the edge where pready is sampled high, reads one edge before
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && penable && !pwrite && !pready;
    assign sense[0] = mcu_control_reg_q[epi_pkg::SENSE0_LSB +: 2];
    assign sense[1] = mcu_control_reg_q[epi_pkg::SENSE1_LSB +: 2];

    // per-register write strobes
    assign wr_mask   = wr_en && paddr == epi_pkg::ADDR_IRQ_MASK;
    assign wr_flag   = wr_en && paddr == epi_pkg::ADDR_IRQ_FLAG;
    assign wr_pcmask = wr_en && paddr == epi_pkg::ADDR_PINCHG_MASK;
    assign wr_ctrl   = wr_en && paddr == epi_pkg::ADDR_MCU_CTRL;
    assign wr_status = wr_en && paddr == epi_pkg::ADDR_CPU_STATUS;

    always_comb begin
        unique case (paddr)
            epi_pkg::ADDR_IRQ_MASK,
            epi_pkg::ADDR_IRQ_FLAG,
            epi_pkg::ADDR_PINCHG_MASK,
            epi_pkg::ADDR_MCU_CTRL,
            epi_pkg::ADDR_CPU_STATUS,
            epi_pkg::ADDR_LINE_STATE: addr_ok = 1'b1;
            default:                  addr_ok = 1'b0;
        endcase
    end

    // apb answer: one wait state, pready pulses for one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // error flagged alongside the answer for an unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && penable && !pready && !addr_ok;
        end
    end

    // read data captured in the first access cycle, held until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_en) begin
            prdata <= rdata_d;
        end
    end

    always_comb begin
        rdata_d = 32'h0;
        unique case (paddr)
            epi_pkg::ADDR_IRQ_MASK:    rdata_d[7:0] = irq_mask_reg_q;
            epi_pkg::ADDR_IRQ_FLAG:    rdata_d[7:0] = irq_flag_reg_q;
            epi_pkg::ADDR_PINCHG_MASK: rdata_d[PC_WIDTH-1:0] = pinchg_mask_reg_q;
            epi_pkg::ADDR_MCU_CTRL:    rdata_d[3:0] = mcu_control_reg_q;
            epi_pkg::ADDR_CPU_STATUS:  rdata_d[epi_pkg::BIT_GIE] = cpu_gie_q;
            epi_pkg::ADDR_LINE_STATE:  rdata_d[1:0] = line_sync_q;
            default:                   rdata_d = 32'h0;
        endcase
    end

    // interrupt mask register, only the source enable bits exist
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg_q <= epi_pkg::RST_BYTE;
        end else if (wr_mask) begin
            irq_mask_reg_q <= pwdata[7:0] & SRC_BITS;
        end
    end

    // pin-change mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pinchg_mask_reg_q <= '0;
        end else if (wr_pcmask) begin
            pinchg_mask_reg_q <= pwdata[PC_WIDTH-1:0];
        end
    end

    // sense selection for both lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcu_control_reg_q <= '0;
        end else if (wr_ctrl) begin
            mcu_control_reg_q <= pwdata[3:0];
        end
    end

    // global interrupt enable, stands in for the cpu's own flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_gie_q <= 1'b0;
        end else if (wr_status) begin
            cpu_gie_q <= pwdata[epi_pkg::BIT_GIE];
        end
    end

    // line synchronisers, sampled regardless of pin direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_meta_q <= '0;
            line_sync_q <= '0;
            line_prev_q <= '0;
        end else begin
            line_meta_q <= {ext_line1_in, ext_line0_in};
            line_sync_q <= line_meta_q;
            line_prev_q <= line_sync_q;
        end
    end

    // pin-change synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_meta_q <= '0;
            pc_sync_q <= '0;
            pc_prev_q <= '0;
        end else begin
            pc_meta_q <= pinchg_inputs;
            pc_sync_q <= pc_meta_q;
            pc_prev_q <= pc_sync_q;
        end
    end

    // per-line sense decode
    for (genvar i = 0; i < 2; i++) begin : g_line
        always_comb begin
            line_level[i] = 1'b0;
            unique case (sense[i])
                epi_pkg::SENSE_LOW: begin
                    line_trig[i]  = 1'b0;
                    line_level[i] = !line_sync_q[i];
                end
                epi_pkg::SENSE_ANY:     line_trig[i] = line_sync_q[i] ^ line_prev_q[i];
                epi_pkg::SENSE_FALLING: line_trig[i] = line_prev_q[i] && !line_sync_q[i];
                epi_pkg::SENSE_RISING:  line_trig[i] = !line_prev_q[i] && line_sync_q[i];
            endcase
        end
    end

    assign pc_trig = |((pc_sync_q ^ pc_prev_q) & pinchg_mask_reg_q);

    always_comb begin
        flag_set = '0;
        flag_set[epi_pkg::BIT_LINE1]  = line_trig[1];
        flag_set[epi_pkg::BIT_LINE0]  = line_trig[0];
        flag_set[epi_pkg::BIT_PINCHG] = pc_trig;
        flag_clr = '0;
        if (wr_flag) begin
            flag_clr = pwdata[7:0];
        end
        if (irq_ack[epi_pkg::VEC_LINE1]) begin
            flag_clr[epi_pkg::BIT_LINE1] = 1'b1;
        end
        if (irq_ack[epi_pkg::VEC_LINE0]) begin
            flag_clr[epi_pkg::BIT_LINE0] = 1'b1;
        end
        if (irq_ack[epi_pkg::VEC_PINCHG]) begin
            flag_clr[epi_pkg::BIT_PINCHG] = 1'b1;
        end
        flag_d = (irq_flag_reg_q & ~flag_clr) | flag_set;
        if (sense[1] == epi_pkg::SENSE_LOW) begin
            flag_d[epi_pkg::BIT_LINE1] = 1'b0;
        end
        if (sense[0] == epi_pkg::SENSE_LOW) begin
            flag_d[epi_pkg::BIT_LINE0] = 1'b0;
        end
        flag_d = flag_d & SRC_BITS;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag_reg_q <= epi_pkg::RST_BYTE;
        end else begin
            irq_flag_reg_q <= flag_d;
        end
    end

    // per-source enable: own mask bit and global enable together
    always_comb begin
        src_en = '0;
        src_en[epi_pkg::VEC_LINE1]  = irq_mask_reg_q[epi_pkg::BIT_LINE1];
        src_en[epi_pkg::VEC_LINE0]  = irq_mask_reg_q[epi_pkg::BIT_LINE0];
        src_en[epi_pkg::VEC_PINCHG] = irq_mask_reg_q[epi_pkg::BIT_PINCHG];
        src_en = src_en & {epi_pkg::NUM_VEC{cpu_gie_q}};
    end

    // pending source: next flag value, or a low level on a level-sensed line
    always_comb begin
        src_pend = '0;
        src_pend[epi_pkg::VEC_LINE1]  = flag_d[epi_pkg::BIT_LINE1] || line_level[1];
        src_pend[epi_pkg::VEC_LINE0]  = flag_d[epi_pkg::BIT_LINE0] || line_level[0];
        src_pend[epi_pkg::VEC_PINCHG] = flag_d[epi_pkg::BIT_PINCHG];
    end

    // one request line per vector, dropped while its handler starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_vec_req <= '0;
        end else begin
            irq_vec_req <= src_en & src_pend & ~irq_ack;
        end
    end

    // clockless wake terms: raw pin-change pins against the synchronised copy, raw line levels alone
    assign pc_wake = irq_mask_reg_q[epi_pkg::BIT_PINCHG]
        && |(pinchg_mask_reg_q & (pinchg_inputs ^ pc_sync_q));
    assign line_wake[1] = irq_mask_reg_q[epi_pkg::BIT_LINE1]
        && sense[1] == epi_pkg::SENSE_LOW && !ext_line1_in;
    assign line_wake[0] = irq_mask_reg_q[epi_pkg::BIT_LINE0]
        && sense[0] == epi_pkg::SENSE_LOW && !ext_line0_in;

    // wake request, registered so the output comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= pc_wake || (|line_wake);
        end
    end
endmodule : epi_ctrl
`default_nettype wire

// file: tb/epi_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module epi_chk #(
    parameter int PC_WIDTH = 8
) (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [7:0]                  paddr,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic [PC_WIDTH-1:0]         pinchg_inputs,
    input wire logic [epi_pkg::NUM_VEC-1:0] irq_ack,
    input wire logic [epi_pkg::NUM_VEC-1:0] irq_vec_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence acc_s; psel && penable && !pready; endsequence
    sequence bad_s; acc_s ##0 paddr > 8'h14; endsequence
    apb_answer_a: assert property (acc_s |=> pready ##1 !pready)
        else $error("access not answered by one pready pulse");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    bad_addr_err_a: assert property (bad_s |=> pslverr)
        else $error("unmapped access without pslverr");
    bad_addr_zero_a: assert property (bad_s ##0 !pwrite |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    reset_quiet_a: assert property ($rose(presetn) |-> irq_vec_req == 3'h0 && !pready)
        else $error("outputs active after reset");
    pc_cause_a: assert property ($rose(irq_vec_req[2]) |->
        $past(pinchg_inputs, 2) != $past(pinchg_inputs, 5) || $past(psel && pwrite)
        || $past(psel && pwrite, 2)) else $error("pin-change request without cause");
    pc_ack_a: assert property (irq_ack[2] && pinchg_inputs == $past(pinchg_inputs, 4)
        |-> ##[1:2] !irq_vec_req[2]) else $error("request kept after handler start");
endmodule : epi_chk
bind epi_ctrl epi_chk #(.PC_WIDTH(PC_WIDTH)) chk_u (.*);
`default_nettype wire

// file: tb/epi_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module epi_cpu_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       accept_en,
    input  wire logic [2:0] irq_vec_req,
    output logic      [2:0] irq_ack
);
    // one handler start per pending vector while accepting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_ack <= 3'h0;
        else
            irq_ack <= irq_vec_req & ~irq_ack & {3{accept_en}};
    end
endmodule : epi_cpu_model
`default_nettype wire

// file: tb/epi_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module epi_ctrl_bench;
    logic        pclk, presetn, psel, penable, pwrite, accept_en, pready, pslverr, wake_req, e;
    logic [7:0]  paddr, pinchg_inputs;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  line;
    logic [2:0]  irq_vec_req, irq_ack;
    int          mismatches, num_checks, m, l;
    wire         ext_line0_in = line[0];
    wire         ext_line1_in = line[1];
    epi_ctrl dut_u (.*);
    epi_cpu_model cpu_u (.*);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rd, x);
    endtask : rdc
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        #50000;
        mismatches++;
        finish_test();
    end
    initial begin
        {psel, penable, pwrite, accept_en} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        line = 2'h3;
        pinchg_inputs = 8'h00;
        mismatches = 0;
        num_checks = 0;
        presetn = 1'b0;
        tick(2);
        presetn <= 1'b1;
        for (m = 0; m < 4; m++) rdc(8'(4 * m), 32'h0);
        apb(1'b1, epi_pkg::ADDR_CPU_STATUS, 32'h80);
        apb(1'b1, epi_pkg::ADDR_IRQ_MASK, 32'hE0);
        apb(1'b1, epi_pkg::ADDR_PINCHG_MASK, 32'h01);
        pinchg_inputs <= 8'h02;
        tick(6);
        rdc(epi_pkg::ADDR_IRQ_FLAG, 32'h0);
        pinchg_inputs <= 8'h03;
        tick(6);
        check("req", 32'(irq_vec_req), 32'h4);
        apb(1'b1, epi_pkg::ADDR_IRQ_FLAG, 32'h0);
        rdc(epi_pkg::ADDR_IRQ_FLAG, 32'h20);
        apb(1'b1, epi_pkg::ADDR_IRQ_FLAG, 32'h20);
        rdc(epi_pkg::ADDR_IRQ_FLAG, 32'h0);
        for (l = 0; l < 2; l++) begin
            for (m = 1; m < 4; m++) begin
                apb(1'b1, epi_pkg::ADDR_MCU_CTRL, 32'(m << (2 * l)));
                line[l] <= 1'b0;
                tick(6);
                rdc(epi_pkg::ADDR_IRQ_FLAG, (m < 3) ? 32'h40 << l : 32'h0);
                apb(1'b1, epi_pkg::ADDR_IRQ_FLAG, 32'hE0);
                line[l] <= 1'b1;
                tick(6);
                rdc(epi_pkg::ADDR_IRQ_FLAG, (m != 2) ? 32'h40 << l : 32'h0);
                apb(1'b1, epi_pkg::ADDR_IRQ_FLAG, 32'hE0);
            end
            apb(1'b1, epi_pkg::ADDR_MCU_CTRL, 32'h0);
            line[l] <= 1'b0;
            tick(6);
            check("level", 32'(irq_vec_req), 32'(1 << l));
            check("wake", 32'(wake_req), 32'h1);
            rdc(epi_pkg::ADDR_IRQ_FLAG, 32'h0);
            apb(1'b1, epi_pkg::ADDR_CPU_STATUS, 32'h0);
            tick(4);
            check("gie", 32'(irq_vec_req), 32'h0);
            apb(1'b1, epi_pkg::ADDR_CPU_STATUS, 32'h80);
            line[l] <= 1'b1;
        end
        accept_en <= 1'b1;
        pinchg_inputs <= 8'h02;
        tick(10);
        rdc(epi_pkg::ADDR_IRQ_FLAG, 32'h0);
        check("ack", 32'(irq_vec_req), 32'h0);
        rdc(8'h40, 32'h0);
        check("err", 32'(e), 32'h1);
        finish_test();
    end
endmodule : epi_ctrl_bench
`default_nettype wire
